//--- hw/dma_engine.v
// Four-channel DMA transfer engine with Avalon-MM register slave and CPU bus master
//
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "dma_engine_consts.vh"

module dma_engine #(
   parameter NCH = 4
) (
   input wire CLK,
   input wire RESET_N,
   input wire [6:0] AVS_ADDRESS,
   input wire AVS_READ,
   input wire AVS_WRITE,
   input wire [31:0] AVS_WRITEDATA,
   input wire [3:0] AVS_BYTEENABLE,
   output reg [31:0] AVS_READDATA,
   output wire AVS_WAITREQUEST,
   output wire BUS_REQUEST,
   input wire BUS_GRANT,
   output wire [23:0] M_ADDRESS,
   output wire M_READ,
   output wire M_WRITE,
   output wire M_WORD,
   output wire [15:0] M_WRITEDATA,
   input wire [15:0] M_READDATA,
   input wire M_WAIT,
   input wire [NCH-1:0] CHANNEL_REQUEST_LINE,
   output wire [NCH-1:0] CHANNEL_ACK,
   input wire FREEZE,
   output wire [NCH-1:0] IRQ
);

// --------------------------------------------------
// Engine states
// --------------------------------------------------
localparam [1:0] S_IDLE = 2'h0;
localparam [1:0] S_REQ = 2'h1;
localparam [1:0] S_RD = 2'h2;
localparam [1:0] S_WR = 2'h3;

// --------------------------------------------------
// Helpers
// --------------------------------------------------
// Byte-lane merge of a write into the old word
function [31:0] merge;
   input [31:0] old;
   input [31:0] dat;
   input [3:0] be;
   integer i;
   begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
      begin
         if (be[i])
            merge[i*8 +: 8] = dat[i*8 +: 8];
      end
   end
endfunction

// Address step
function [23:0] step;
   input [23:0] a;
   input [1:0] code;
   begin
      case (code)
         2'h0: step = a + 24'h000001;
         2'h1: step = a + 24'h000002;
         2'h2: step = a - 24'h000001;
         default: step = a - 24'h000002;
      endcase
   end
endfunction

// --------------------------------------------------
// Declarations
// --------------------------------------------------
reg [1:0] state_reg;
reg [1:0] ch_reg;
reg [15:0] hold_reg;
reg ack_reg;
reg [31:0] rd_val;
reg [1:0] pick;
wire [23:0] a_w [0:NCH-1], ar_w [0:NCH-1], b_w [0:NCH-1], br_w [0:NCH-1];
wire [15:0] l_w [0:NCH-1], lr_w [0:NCH-1], c_w [0:NCH-1];
wire [3:0] s_w [0:NCH-1];
wire [NCH-1:0] want;
wire [NCH-1:0] term;
wire [1:0] ach;
wire [4:0] rsel;
wire [31:0] wm;
wire [3:0] w1c;
wire [15:0] cur_ctl;
wire bus_wr, cur_ind, cur_dir, any_want, done, cont;

// --------------------------------------------------
// Avalon-MM slave
// --------------------------------------------------
// One wait cycle per access so read data comes from a flop
assign ach = AVS_ADDRESS[6:5];
assign rsel = AVS_ADDRESS[4:0];
assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
assign bus_wr = AVS_WRITE & ack_reg;
assign wm = merge(rd_val, AVS_WRITEDATA, AVS_BYTEENABLE);
// Status is write-one-to-clear, so no merge with old bits
assign w1c = AVS_WRITEDATA[3:0] & {4{AVS_BYTEENABLE[0]}};

// Read mux; unmapped indices read zero
always @*
begin
   rd_val = 32'h00000000;
   case (rsel)
      `OFS_A_CNT: rd_val = {8'h00, a_w[ach]};
      `OFS_A_RLD: rd_val = {8'h00, ar_w[ach]};
      `OFS_B_CNT: rd_val = {8'h00, b_w[ach]};
      `OFS_B_RLD: rd_val = {8'h00, br_w[ach]};
      `OFS_LEN_CNT: rd_val = {16'h0000, l_w[ach]};
      `OFS_LEN_RLD: rd_val = {16'h0000, lr_w[ach]};
      `OFS_CTL: rd_val = {16'h0000, c_w[ach]};
      `OFS_STAT: rd_val = {28'h0000000, s_w[ach]};
      default: rd_val = 32'h00000000;
   endcase
end

// Acknowledge and read data flops
always @(posedge CLK or negedge RESET_N)
begin
   if (!RESET_N)
   begin
      ack_reg <= 1'b0;
      AVS_READDATA <= 32'h00000000;
   end
   else
   begin
      ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
      if (AVS_READ & ~ack_reg)
         AVS_READDATA <= rd_val;
   end
end

// --------------------------------------------------
// Channels
// --------------------------------------------------
genvar n;
generate
   for (n = 0; n < NCH; n = n + 1)
   begin : chan
      localparam [1:0] IDX = n;
      reg [23:0] a_cnt_reg, a_rld_reg, b_cnt_reg, b_rld_reg;
      reg [15:0] len_cnt_reg, len_rld_reg, ctl_reg;
      reg channel_active_flag_reg, tc_reg, ovr_reg, vld_reg, irq_reg;
      wire wr, mine, ind;
      wire [15:0] dec;

      assign wr = bus_wr & (ach == IDX);
      assign mine = done & (ch_reg == IDX);
      assign ind = ctl_reg[`CTL_IND];
      // Zero length counts as 65535 items
      assign dec = (len_cnt_reg == 16'h0000) ? `LEN_ZERO_DEC : len_cnt_reg - 16'h0001;
      assign term[n] = (dec == 16'h0000);
      // Request from line or software bit, only while enabled and active
      assign want[n] = ctl_reg[`CTL_CHANNEL_ENABLE] & channel_active_flag_reg &
                       (CHANNEL_REQUEST_LINE[n] | ctl_reg[`CTL_SOFT_REQUEST]);
      assign a_w[n] = a_cnt_reg;
      assign ar_w[n] = a_rld_reg;
      assign b_w[n] = b_cnt_reg;
      assign br_w[n] = b_rld_reg;
      assign l_w[n] = len_cnt_reg;
      assign lr_w[n] = len_rld_reg;
      assign c_w[n] = ctl_reg;
      assign s_w[n] = {vld_reg, ovr_reg, tc_reg, channel_active_flag_reg};
      assign IRQ[n] = irq_reg;

      // Software writes first, engine updates after so hardware sets win
      always @(posedge CLK or negedge RESET_N)
      begin
         if (!RESET_N)
         begin
            a_cnt_reg <= `RST_ADDR;
            a_rld_reg <= `RST_ADDR;
            b_cnt_reg <= `RST_ADDR;
            b_rld_reg <= `RST_ADDR;
            len_cnt_reg <= `RST_HALF;
            len_rld_reg <= `RST_HALF;
            ctl_reg <= `RST_HALF;
            channel_active_flag_reg <= 1'b0;
            tc_reg <= 1'b0;
            ovr_reg <= 1'b0;
            vld_reg <= 1'b0;
            irq_reg <= 1'b0;
         end
         else
         begin
            if (wr & (rsel == `OFS_A_CNT))
               a_cnt_reg <= wm[23:0];
            if (wr & (rsel == `OFS_A_RLD))
               a_rld_reg <= wm[23:0];
            if (wr & (rsel == `OFS_B_CNT))
               b_cnt_reg <= wm[23:0];
            if (wr & (rsel == `OFS_B_RLD))
               b_rld_reg <= wm[23:0];
            if (wr & (rsel == `OFS_LEN_CNT))
               len_cnt_reg <= wm[15:0];
            if (wr & (rsel == `OFS_LEN_RLD))
               len_rld_reg <= wm[15:0];
            // A written enable of 1 restarts the channel even if already set
            if (wr & (rsel == `OFS_CTL))
            begin
               ctl_reg <= wm[15:0] & `CTL_MASK;
               channel_active_flag_reg <= wm[`CTL_CHANNEL_ENABLE];
            end
            if (wr & (rsel == `OFS_STAT))
            begin
               tc_reg <= tc_reg & ~w1c[`ST_TC];
               ovr_reg <= ovr_reg & ~w1c[`ST_OVR];
               vld_reg <= vld_reg & ~w1c[`ST_VLD];
            end
            // Item finished on this channel
            if (mine)
            begin
               len_cnt_reg <= dec;
               if (ctl_reg[`CTL_ADA])
                  a_cnt_reg <= step(a_cnt_reg, ctl_reg[`CTL_DEVICE_A_STEP_SIZE+1:`CTL_DEVICE_A_STEP_SIZE]);
               if (ind & ctl_reg[`CTL_ADB])
                  b_cnt_reg <= step(b_cnt_reg, ctl_reg[`CTL_DEVICE_B_STEP_SIZE+1:`CTL_DEVICE_B_STEP_SIZE]);
               if (term[n])
               begin
                  if (ctl_reg[`CTL_OT])
                  begin
                     // Auto-initialize keeps going
                     a_cnt_reg <= a_rld_reg;
                     len_cnt_reg <= len_rld_reg;
                     if (ind)
                        b_cnt_reg <= b_rld_reg;
                     if (tc_reg)
                        ovr_reg <= 1'b1;
                     else
                        tc_reg <= 1'b1;
                  end
                  else if (vld_reg)
                  begin
                     a_cnt_reg <= a_rld_reg;
                     len_cnt_reg <= len_rld_reg;
                     if (ind)
                        b_cnt_reg <= b_rld_reg;
                     vld_reg <= 1'b0;
                     tc_reg <= 1'b1;
                  end
                  else
                  begin
                     tc_reg <= 1'b1;
                     ovr_reg <= 1'b1;
                     channel_active_flag_reg <= 1'b0;
                  end
               end
            end
            // Reload length write marks next block valid, winning over a clear
            if (wr & (rsel == `OFS_LEN_RLD))
               vld_reg <= 1'b1;
            // Level interrupt from flags and enables
            irq_reg <= (tc_reg & ctl_reg[`CTL_ETC]) | (ovr_reg & ctl_reg[`CTL_OVERRUN_IRQ_ENABLE]);
         end
      end
   end
endgenerate

// --------------------------------------------------
// Arbitration
// --------------------------------------------------
assign any_want = |want;

// Lowest channel number wins
always @*
begin
   pick = want[0] ? 2'h0 : want[1] ? 2'h1 : want[2] ? 2'h2 : 2'h3;
end

// --------------------------------------------------
// Transfer sequencer
// --------------------------------------------------
assign cur_ctl = c_w[ch_reg];
assign cur_ind = cur_ctl[`CTL_IND];
assign cur_dir = cur_ctl[`CTL_DIR];
// An item ends on the last bus cycle it needs
assign done = ((state_reg == S_RD) & ~cur_ind & ~M_WAIT) |
              ((state_reg == S_WR) & ~M_WAIT);
// Burst only while requested; a block end always returns the bus
assign cont = cur_ctl[`CTL_BPC] & want[ch_reg] & ~term[ch_reg] & ~FREEZE;

// An item already on the bus completes; freeze blocks the next one
always @(posedge CLK or negedge RESET_N)
begin
   if (!RESET_N)
   begin
      state_reg <= S_IDLE;
      ch_reg <= 2'h0;
      hold_reg <= 16'h0000;
   end
   else
   begin
      case (state_reg)
         S_IDLE:
         begin
            if (~FREEZE & any_want)
            begin
               state_reg <= S_REQ;
               ch_reg <= pick;
            end
         end
         S_REQ:
         begin
            if (FREEZE | ~any_want)
               state_reg <= S_IDLE;
            else
            begin
               // Re-chosen every clock, so the last pick sits one clock before T1
               ch_reg <= pick;
               if (BUS_GRANT)
                  state_reg <= S_RD;
            end
         end
         S_RD:
         begin
            if (~M_WAIT)
            begin
               if (cur_ind)
               begin
                  hold_reg <= M_READDATA;
                  state_reg <= S_WR;
               end
               else if (cont)
                  state_reg <= S_RD;
               else
                  state_reg <= S_IDLE;
            end
         end
         S_WR:
         begin
            if (~M_WAIT)
               state_reg <= cont ? S_RD : S_IDLE;
         end
         default: state_reg <= S_IDLE;
      endcase
   end
end

// --------------------------------------------------
// Bus master outputs
// --------------------------------------------------
// Direct cycles use counter A only; indirect picks by direction
assign M_ADDRESS = (state_reg == S_WR) ? (cur_dir ? a_w[ch_reg] : b_w[ch_reg]) :
                   (cur_ind & cur_dir) ? b_w[ch_reg] : a_w[ch_reg];
assign M_READ = (state_reg == S_RD) & (cur_ind | ~cur_dir);
assign M_WRITE = (state_reg == S_WR) | ((state_reg == S_RD) & ~cur_ind & cur_dir);
assign M_WORD = (state_reg[1]) & cur_ctl[`CTL_TCS];
// Direct data flows between devices; only indirect drives held data
assign M_WRITEDATA = (state_reg == S_WR) ? hold_reg : 16'h0000;
assign BUS_REQUEST = (state_reg != S_IDLE);

// Acknowledge the serviced channel during its bus cycles
generate
   for (n = 0; n < NCH; n = n + 1)
   begin : ackgen
      localparam [1:0] IDX = n;
      assign CHANNEL_ACK[n] = state_reg[1] & (ch_reg == IDX);
   end
endgenerate

endmodule // dma_engine

//--- hw/dma_engine_consts.vh
// Register indices, field positions and reset values of the four-channel DMA engine
`ifndef DMA_ENGINE_CONSTS_VH
`define DMA_ENGINE_CONSTS_VH

// --------------------------------------------------
// Register indices inside one channel block
// --------------------------------------------------
`define OFS_A_CNT 5'h00
`define OFS_A_RLD 5'h04
`define OFS_B_CNT 5'h08
`define OFS_B_RLD 5'h0c
`define OFS_LEN_CNT 5'h10
`define OFS_LEN_RLD 5'h14
`define OFS_CTL 5'h1c
`define OFS_STAT 5'h1e

// --------------------------------------------------
// Channel control field positions
// --------------------------------------------------
`define CTL_CHANNEL_ENABLE 0
`define CTL_ETC 1
`define CTL_OVERRUN_IRQ_ENABLE 2
`define CTL_TCS 3
`define CTL_IND 4
`define CTL_DIR 5
`define CTL_OT 6
`define CTL_BPC 7
`define CTL_SOFT_REQUEST 8
`define CTL_ADA 9
`define CTL_DEVICE_A_STEP_SIZE 10
`define CTL_ADB 12
`define CTL_DEVICE_B_STEP_SIZE 13
`define CTL_MASK 16'h7fff

// --------------------------------------------------
// Channel status field positions
// --------------------------------------------------
`define ST_CHANNEL_ACTIVE_FLAG 0
`define ST_TC 1
`define ST_OVR 2
`define ST_VLD 3

// --------------------------------------------------
// Reset values and special counts
// --------------------------------------------------
`define RST_ADDR 24'h000000
`define RST_HALF 16'h0000
`define LEN_ZERO_DEC 16'hfffe

`endif

//--- tb/cpu_bus_model.sv
// Behavioural CPU bus: grant, small memory, optional wait states
`timescale 1ns/1ps
module cpu_bus_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic breq,
   output logic bgnt,
   input wire logic [23:0] m_addr,
   input wire logic m_rd,
   input wire logic m_wr,
   input wire logic [15:0] m_wd,
   output logic [15:0] m_rdata,
   output logic m_wait
);
   logic [15:0] mem [0:255];
   logic [15:0] last_reg;
   logic grant_reg, stall_reg;
   // Distinct contents per address so a copy is traceable
   initial
      for (int i = 0; i < 256; i++)
         mem[i] = {8'hc3, i[7:0]};
   // Slow mode grants a cycle late and stalls each cycle once
   assign bgnt = slow ? grant_reg : breq;
   assign m_wait = slow & (m_rd | m_wr) & ~stall_reg;
   // A released data bus never shows a stale copy
   assign m_rdata = m_rd ? mem[m_addr[7:0]] : ~last_reg;
   // Grant follows request, so it holds while requested
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         grant_reg <= 1'b0;
         stall_reg <= 1'b0;
         last_reg <= 16'h0000;
      end
      else
      begin
         grant_reg <= breq;
         stall_reg <= m_wait;
         if (m_rd && !m_wait)
            last_reg <= m_rdata;
         if (m_wr && !m_wait)
            mem[m_addr[7:0]] <= m_wd;
      end
   end
endmodule // cpu_bus_model

//--- tb/dma_engine_asserts.sv
// Port-level assertions for the DMA engine
`timescale 1ns/1ps
module dma_engine_asserts #(
   parameter NCH = 4
) (
   input wire CLK,
   input wire RESET_N,
   input wire BUS_REQUEST,
   input wire BUS_GRANT,
   input wire [23:0] M_ADDRESS,
   input wire M_READ,
   input wire M_WRITE,
   input wire M_WORD,
   input wire [15:0] M_WRITEDATA,
   input wire [15:0] M_READDATA,
   input wire M_WAIT,
   input wire [NCH-1:0] CHANNEL_ACK,
   input wire FREEZE
);
   // ----
   // Bus cycle steps
   // ----
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESET_N);
   sequence s_rd_end;
      M_READ && !M_WAIT;
   endsequence
   sequence s_wr;
      M_WRITE;
   endsequence
   // Cycles only on a granted bus, chosen a clock ahead
   a_cycle_granted: assert property ((M_READ || M_WRITE) |-> BUS_REQUEST && BUS_GRANT)
      else $error("cycle without grant");
   a_req_before_t1: assert property ($rose(M_READ | M_WRITE) |-> $past(BUS_REQUEST))
      else $error("cycle without request cycle");
   a_one_direction: assert property (!(M_READ && M_WRITE))
      else $error("read and write together");
   a_ack_onehot: assert property ($onehot0(CHANNEL_ACK))
      else $error("two channels served");
   a_ack_in_cycle: assert property ((CHANNEL_ACK != '0) == (M_READ || M_WRITE))
      else $error("ack outside cycle");
   // A stalled read keeps its address
   a_cycle_stands: assert property (M_READ && M_WAIT |=> M_READ && $stable(M_ADDRESS))
      else $error("stalled read moved");
   // The write of an indirect item carries the data just read
   a_hold_copy: assert property (s_rd_end ##1 s_wr |-> M_WRITEDATA == $past(M_READDATA))
      else $error("held data lost");
   a_freeze_idle: assert property (FREEZE && !BUS_REQUEST |=> !BUS_REQUEST)
      else $error("request under freeze");
   a_word_idle: assert property (!(M_READ || M_WRITE) |-> !M_WORD)
      else $error("size outside cycle");
endmodule // dma_engine_asserts

bind dma_engine dma_engine_asserts #(.NCH(NCH)) checker_i (.CLK(CLK), .RESET_N(RESET_N),
   .BUS_REQUEST(BUS_REQUEST), .BUS_GRANT(BUS_GRANT), .M_ADDRESS(M_ADDRESS), .M_READ(M_READ),
   .M_WRITE(M_WRITE), .M_WORD(M_WORD), .M_WRITEDATA(M_WRITEDATA), .M_READDATA(M_READDATA),
   .M_WAIT(M_WAIT), .CHANNEL_ACK(CHANNEL_ACK), .FREEZE(FREEZE));

//--- tb/dma_engine_test.sv
// Self-checking bench for the DMA engine
`timescale 1ns/1ps
`include "dma_engine_consts.vh"
module dma_engine_test;
   // ----
   // Bench signals
   // ----
   logic clk = 1'b0, rst_n = 1'b0, av_rd = 1'b0, av_wr = 1'b0, freeze = 1'b0, slow = 1'b0;
   logic [6:0] av_addr = 7'h00;
   logic [31:0] av_wd = 32'h00000000;
   logic [3:0] lines = 4'h0;
   wire [31:0] av_rdata;
   wire [23:0] m_addr;
   wire [15:0] m_wd, m_rdata;
   wire [3:0] ack, irq;
   wire av_wait, breq, bgnt, m_rd, m_wr, m_word, m_wait;
   int failures = 0, checks = 0, cyc = 0;
   logic [24:0] seen[$];
   logic words[$];
   int at[$];
   logic [31:0] v;
   always #20 clk = ~clk;
   dma_engine #(.NCH(4)) dut (.CLK(clk), .RESET_N(rst_n), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
      .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wd), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(av_rdata),
      .AVS_WAITREQUEST(av_wait), .BUS_REQUEST(breq), .BUS_GRANT(bgnt), .M_ADDRESS(m_addr), .M_READ(m_rd),
      .M_WRITE(m_wr), .M_WORD(m_word), .M_WRITEDATA(m_wd), .M_READDATA(m_rdata), .M_WAIT(m_wait),
      .CHANNEL_REQUEST_LINE(lines), .CHANNEL_ACK(ack), .FREEZE(freeze), .IRQ(irq));
   cpu_bus_model bus (.clk(clk), .rst_n(rst_n), .slow(slow), .breq(breq), .bgnt(bgnt), .m_addr(m_addr),
      .m_rd(m_rd), .m_wr(m_wr), .m_wd(m_wd), .m_rdata(m_rdata), .m_wait(m_wait));
   // Log finished bus cycles; the stamp gives throughput
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if ((m_rd | m_wr) && !m_wait)
      begin
         seen.push_back({m_wr, m_addr});
         words.push_back(m_word);
         at.push_back(cyc);
      end
   end
   // ----
   // Shared tasks
   // ----
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Request stands until an edge samples waitrequest low
   // Only the watchdog ends a wait that never sees waitrequest low
   task automatic av(input logic w, input logic [6:0] a, input logic [31:0] d);
      @(posedge clk);
      av_addr <= a;
      av_wr <= w;
      av_rd <= !w;
      av_wd <= d;
      do
      begin
         @(posedge clk);
      end
      while (av_wait);
      v = av_rdata;
      av_rd <= 1'b0;
      av_wr <= 1'b0;
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      av(1'b1, a, d);
   endtask
   task automatic rd(input logic [6:0] a, input logic [31:0] exp);
      av(1'b0, a, 32'h0);
      chk(v, exp);
   endtask
   task automatic setup(input logic [1:0] c, input logic [31:0] a, b, len, ctl);
      wr({c, `OFS_CTL}, 32'h0);
      wr({c, `OFS_A_CNT}, a);
      wr({c, `OFS_B_CNT}, b);
      wr({c, `OFS_LEN_CNT}, len);
      wr({c, `OFS_STAT}, 32'he);
      seen.delete();
      at.delete();
      words.delete();
      wr({c, `OFS_CTL}, ctl);
   endtask
   // Bounded wait for n cycles, then let flags settle
   task automatic run(input int n);
      int k = 0;
      while (seen.size() < n && k < 400)
      begin
         @(posedge clk);
         k++;
      end
      if (k == 400)
         failures++;
      repeat (4) @(posedge clk);
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_regs;
      rd({2'h0, `OFS_STAT}, 32'h0);
      wr({2'h1, `OFS_A_RLD}, 32'hffffffff);
      rd({2'h1, `OFS_A_RLD}, 32'h00ffffff);
      rd({2'h1, 5'h18}, 32'h0);
      wr({2'h1, `OFS_LEN_RLD}, 32'h5);
      rd({2'h1, `OFS_STAT}, 32'h8);
      wr({2'h1, `OFS_STAT}, 32'h8);
      rd({2'h1, `OFS_STAT}, 32'h0);
      $display("regs done");
   endtask
   task automatic t_direct;
      setup(2'h0, 32'h10, 32'h55, 32'h3, 32'h0603);
      lines <= 4'h1;
      run(3);
      lines <= 4'h0;
      for (int i = 0; i < 3; i++)
         chk(seen[i], 32'h10 + 2 * i);
      chk(seen.size(), 3);
      chk(at[1] - at[0], 3);
      chk(words[0], 1'b0);
      rd({2'h0, `OFS_STAT}, 32'h6);
      chk(irq[0], 1'b1);
      rd({2'h0, `OFS_A_CNT}, 32'h16);
      rd({2'h0, `OFS_LEN_CNT}, 32'h0);
      rd({2'h0, `OFS_B_CNT}, 32'h55);
      $display("direct done");
   endtask
   task automatic t_indirect;
      setup(2'h1, 32'h40, 32'h20, 32'h2, 32'h1fb9);
      run(4);
      chk(seen[0], 32'h20);
      chk(seen[1], 32'h1000040);
      chk(seen[2], 32'h21);
      chk(seen[3], 32'h100003e);
      chk(at[2] - at[0], 2);
      chk(words[1], 1'b1);
      chk(bus.mem[8'h3e], 32'hc321);
      wr({2'h1, `OFS_CTL}, 32'h0);
      rd({2'h1, `OFS_STAT}, 32'h6);
      $display("indirect done");
   endtask
   task automatic t_double;
      setup(2'h2, 32'h60, 32'h0, 32'h1, 32'h5);
      wr({2'h2, `OFS_A_RLD}, 32'h80);
      wr({2'h2, `OFS_B_RLD}, 32'h77);
      wr({2'h2, `OFS_LEN_RLD}, 32'h1);
      rd({2'h2, `OFS_STAT}, 32'h9);
      lines <= 4'h4;
      run(2);
      lines <= 4'h0;
      chk(seen[1], 32'h80);
      chk(seen.size(), 2);
      rd({2'h2, `OFS_STAT}, 32'h6);
      chk(irq[2], 1'b1);
      rd({2'h2, `OFS_B_CNT}, 32'h0);
      $display("double done");
   endtask
   task automatic t_auto;
      setup(2'h3, 32'h90, 32'h0, 32'h2, 32'h265);
      wr({2'h3, `OFS_A_RLD}, 32'h90);
      wr({2'h3, `OFS_LEN_RLD}, 32'h2);
      lines <= 4'h8;
      run(4);
      lines <= 4'h0;
      for (int i = 0; i < 4; i++)
         chk(seen[i], 32'h1000090 + i % 2);
      av(1'b0, {2'h3, `OFS_STAT}, 32'h0);
      chk(v[2:0], 3'h7);
      chk(irq[3], 1'b1);
      wr({2'h3, `OFS_CTL}, 32'h0);
      seen.delete();
      lines <= 4'h8;
      repeat (12) @(posedge clk);
      lines <= 4'h0;
      chk(seen.size(), 0);
      $display("auto done");
   endtask
   // Freeze first, then both channels race on a slow bus
   task automatic t_freeze;
      setup(2'h2, 32'h60, 32'h0, 32'h1, 32'h1);
      setup(2'h3, 32'h70, 32'h0, 32'h1, 32'h1);
      freeze <= 1'b1;
      slow <= 1'b1;
      lines <= 4'hc;
      repeat (10) @(posedge clk);
      chk(seen.size(), 0);
      freeze <= 1'b0;
      run(2);
      chk(seen[0], 32'h60);
      chk(seen[1], 32'h70);
      $display("freeze done");
   endtask
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_direct;
      t_indirect;
      t_double;
      t_auto;
      t_freeze;
      finish_test;
   end
   // Tests need about 300 cycles; allow far more
   initial
   begin
      #800000;
      failures++;
      finish_test;
   end
endmodule // dma_engine_test
